/* logic/uart_channel.sv */
// one serial channel: host strobes, dma ready pins, loopback, auto clear-to-send
// Operation
// RL1: receive-ready goes low at rx trigger level or on receive timeout.
// RL2: receive-ready goes high when rx fifo is empty or holds an errored character.
// RL3: transmit-ready goes low when free tx locations reach the trigger level.
// RL4: transmit-ready goes high when the tx fifo is full.
// RL5: loopback holds the tx pin idle and feeds tx serial data to the receiver.
// RL6: three register-select inputs choose the register a strobe accesses.
// RL7: transfers are accepted only while this channel's select is low.
// RL8: the modem drives clear-to-send low when it can accept data.
// RL9: clear-to-send state reads back in modem status bit 4.
// RL10: clear-to-send gates transmission only when enhanced feature bit 7 is set.
// RL11: modem control bit 1 drives request-to-send low; reset drives it high.
// RL12: dma ready outputs come only from this channel's own fifo state.
`timescale 1ns/1ps
`default_nettype none
`include "uart_pins_consts.svh"
module dma_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int CW = 5
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [CW-1:0] level
);
	typedef struct packed {
		logic [CW-2:0] wp;
		logic [CW-2:0] rp;
		logic [CW-1:0] cnt;
	} fifo_state_type;
	fifo_state_type st_r, st_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;
	assign in_ready = st_r.cnt != CW'(DEPTH);
	assign out_valid = st_r.cnt != '0;
	assign out_data = mem[st_r.rp];
	assign level = st_r.cnt;
	assign push = in_valid && in_ready;
	assign pop = out_ready && out_valid;
	always_comb begin
		st_nxt = st_r;
		st_nxt.wp = st_r.wp + (CW-1)'(push);
		st_nxt.rp = st_r.rp + (CW-1)'(pop);
		st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
		if (push) begin
			mem[st_r.wp] <= in_data;
		end
	end
endmodule

module uart_channel #(
	parameter logic [15:0] RX_TIMEOUT_CYCLES = 16'h21e8
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CHANNEL_SELECT_N,
	input wire logic REG_SELECT_BIT0,
	input wire logic REG_SELECT_BIT1,
	input wire logic REG_SELECT_BIT2,
	input wire logic WRITE_STROBE_N,
	input wire logic READ_STROBE_N,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	input wire logic CLEAR_TO_SEND_N,
	output logic REQUEST_TO_SEND_N,
	input wire logic RX,
	output logic TX,
	output logic RX_DMA_READY_N,
	output logic TX_DMA_READY_N
);
	uart_pins_pkg::chan_state_type st_r, st_nxt;
	logic [2:0] addr;
	logic wr_fall, rd_fall, rx_in, tx_line, tx_start, rx_push, rx_pop;
	logic rx_err_in, tx_push, tx_in_ready, tx_out_valid, rx_out_valid, rx_in_ready;
	logic [7:0] tx_out_data;
	logic [8:0] rx_out_data;
	logic [4:0] rx_level, tx_level, tx_free;
	// zero in a trigger field means one, so a ready pin can always assert
	function automatic logic [4:0] trig_level(input logic [3:0] f);
		trig_level = (f == 4'h0) ? 5'h01 : {1'b0, f};
	endfunction
	assign addr = st_r.s2[`PIN_ADDR_HI:`PIN_ADDR_LO];
	assign wr_fall = st_r.wr_prev && !st_r.s2[`PIN_WR] && !st_r.s2[`PIN_CS]; // RL7
	assign rd_fall = st_r.rd_prev && !st_r.s2[`PIN_RD] && !st_r.s2[`PIN_CS]; // RL7
	assign tx_line = st_r.tx_busy ? st_r.tx_sh[0] : 1'b1;
	assign rx_in = st_r.modem_control_reg[`MCR_LOOP] ? tx_line : st_r.s2[`PIN_RX]; // RL5
	assign tx_push = wr_fall && addr == `ADDR_DATA; // RL6
	assign rx_pop = rd_fall && addr == `ADDR_DATA && rx_out_valid; // RL6
	// auto clear-to-send only holds off the next character, never one in flight
	assign tx_start = !st_r.tx_busy && tx_out_valid
		&& !(st_r.enhanced_feature_reg[`EFR_AUTO_CTS] && st_r.s2[`PIN_CTS]); // RL10
	assign rx_push = st_r.rx_busy && st_r.rx_cnt == 8'h00 && st_r.rx_bits == `LAST_BIT;
	assign rx_err_in = !rx_in;
	assign tx_free = 5'(`FIFO_DEPTH) - tx_level;
	dma_fifo #(.WIDTH(`DATA_W + 1), .DEPTH(`FIFO_DEPTH), .CW(`FIFO_CW)) rx_fifo (
		.clock(CLOCK),
		.rst(RST),
		.in_valid(rx_push),
		.in_ready(rx_in_ready),
		.in_data({rx_err_in, st_r.rx_sh}),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop),
		.out_data(rx_out_data),
		.level(rx_level)
	);
	// a full tx fifo drops host writes; the dma ready pin is the back-pressure
	dma_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .CW(`FIFO_CW)) tx_fifo (
		.clock(CLOCK),
		.rst(RST),
		.in_valid(tx_push),
		.in_ready(tx_in_ready),
		.in_data(st_r.s2[7:0]),
		.out_valid(tx_out_valid),
		.out_ready(tx_start),
		.out_data(tx_out_data),
		.level(tx_level)
	);
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = {CLEAR_TO_SEND_N, RX, WRITE_STROBE_N, READ_STROBE_N, CHANNEL_SELECT_N,
			REG_SELECT_BIT2, REG_SELECT_BIT1, REG_SELECT_BIT0, DATA_IN};
		st_nxt.s2 = st_r.s1;
		st_nxt.wr_prev = st_r.s2[`PIN_WR];
		st_nxt.rd_prev = st_r.s2[`PIN_RD];
		if (wr_fall) begin
			if (addr == `ADDR_TRIG) begin // RL6
				st_nxt.trig = st_r.s2[7:0];
			end else if (addr == `ADDR_EFR) begin
				st_nxt.enhanced_feature_reg = st_r.s2[7:0];
			end else if (addr == `ADDR_MCR) begin
				st_nxt.modem_control_reg = st_r.s2[7:0];
			end
		end
		if (rd_fall) begin
			st_nxt.rdata = 8'h00;
			if (addr == `ADDR_DATA) begin // RL6
				st_nxt.rdata = rx_out_data[7:0];
			end else if (addr == `ADDR_TRIG) begin
				st_nxt.rdata = st_r.trig;
			end else if (addr == `ADDR_EFR) begin
				st_nxt.rdata = st_r.enhanced_feature_reg;
			end else if (addr == `ADDR_MCR) begin
				st_nxt.rdata = st_r.modem_control_reg;
			end else if (addr == `ADDR_LSR) begin
				st_nxt.rdata[`LSR_RX_AVAIL] = rx_out_valid;
				st_nxt.rdata[`LSR_RX_ERR] = st_r.err_cnt != 5'h00;
				st_nxt.rdata[`LSR_TX_EMPTY] = !tx_out_valid && !st_r.tx_busy;
			end else if (addr == `ADDR_MSR) begin
				st_nxt.rdata[`MSR_CTS] = !st_r.s2[`PIN_CTS]; // RL9
			end
		end
		st_nxt.rts_n = !st_r.modem_control_reg[`MCR_RTS]; // RL11
		if (tx_start) begin
			st_nxt.tx_busy = 1'b1;
			st_nxt.tx_sh = {1'b1, tx_out_data, 1'b0};
			st_nxt.tx_bits = 4'h0;
			st_nxt.tx_cnt = `BIT_CYCLES;
		end else if (st_r.tx_busy) begin
			st_nxt.tx_cnt = st_r.tx_cnt - 8'h01;
			if (st_r.tx_cnt == 8'h01) begin
				st_nxt.tx_cnt = `BIT_CYCLES;
				st_nxt.tx_sh = {1'b1, st_r.tx_sh[9:1]};
				st_nxt.tx_bits = st_r.tx_bits + 4'h1;
				st_nxt.tx_busy = st_r.tx_bits != `LAST_BIT;
			end
		end
		st_nxt.tx_pin = st_r.modem_control_reg[`MCR_LOOP] ? 1'b1 : tx_line; // RL5
		// receiver, sampling mid-bit
		if (!st_r.rx_busy) begin
			if (!rx_in) begin
				st_nxt.rx_busy = 1'b1;
				st_nxt.rx_cnt = `HALF_BIT_CYCLES;
				st_nxt.rx_bits = 4'h0;
			end
		end else if (st_r.rx_cnt != 8'h00) begin
			st_nxt.rx_cnt = st_r.rx_cnt - 8'h01;
		end else begin
			st_nxt.rx_cnt = `BIT_CYCLES;
			st_nxt.rx_bits = st_r.rx_bits + 4'h1;
			if (st_r.rx_bits == 4'h0) begin
				st_nxt.rx_busy = !rx_in;
			end else if (st_r.rx_bits == `LAST_BIT) begin
				st_nxt.rx_busy = 1'b0;
			end else begin
				st_nxt.rx_sh = {rx_in, st_r.rx_sh[7:1]};
			end
		end
		st_nxt.err_cnt = st_r.err_cnt + 5'(rx_push && rx_in_ready && rx_err_in)
			- 5'(rx_pop && rx_out_data[`ERR_BIT]);
		// timeout: data waiting, no traffic either way
		if (rx_push || rx_pop || !rx_out_valid) begin
			st_nxt.to_cnt = 16'h0000;
			st_nxt.to_flag = 1'b0;
		end else if (st_r.to_cnt == RX_TIMEOUT_CYCLES) begin
			st_nxt.to_flag = 1'b1;
		end else begin
			st_nxt.to_cnt = st_r.to_cnt + 16'h0001;
		end
		if (rx_level == 5'h00 || st_r.err_cnt != 5'h00) begin // RL2 RL12
			st_nxt.rx_rdy_n = 1'b1;
		end else if (rx_level >= trig_level(st_r.trig[3:0]) || st_r.to_flag) begin // RL1
			st_nxt.rx_rdy_n = 1'b0;
		end
		if (tx_level == 5'(`FIFO_DEPTH)) begin // RL4 RL12
			st_nxt.tx_rdy_n = 1'b1;
		end else if (tx_free >= trig_level(st_r.trig[7:4])) begin // RL3
			st_nxt.tx_rdy_n = 1'b0;
		end
	end
	// modem control and enhanced feature registers clear to zero; trig loads 8'h11, the pin stages load 16'hf800 and the ready, tx and rts pins load ones
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			st_r <= '0;
			st_r.s1 <= `PINS_RST;
			st_r.s2 <= `PINS_RST;
			st_r.wr_prev <= 1'b1;
			st_r.rd_prev <= 1'b1;
			st_r.trig <= `TRIG_RST;
			st_r.rx_rdy_n <= 1'b1;
			st_r.tx_rdy_n <= 1'b1;
			st_r.tx_pin <= 1'b1;
			st_r.rts_n <= 1'b1; // RL11
		end else begin
			st_r <= st_nxt;
		end
	end
	assign DATA_OUT = st_r.rdata;
	assign REQUEST_TO_SEND_N = st_r.rts_n;
	assign TX = st_r.tx_pin;
	assign RX_DMA_READY_N = st_r.rx_rdy_n;
	assign TX_DMA_READY_N = st_r.tx_rdy_n;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	property p_rx_empty;
		rx_level == 5'h00 |=> RX_DMA_READY_N;
	endproperty
	a_rx_empty: assert property (p_rx_empty) else $error("rx ready low with empty fifo"); // RL2
	property p_rx_err;
		st_r.err_cnt != 5'h00 |=> RX_DMA_READY_N;
	endproperty
	a_rx_err: assert property (p_rx_err) else $error("rx ready low with errored char"); // RL2
	property p_rx_trig;
		rx_level != 5'h00 && st_r.err_cnt == 5'h00 && rx_level >= trig_level(st_r.trig[3:0]) |=> !RX_DMA_READY_N;
	endproperty
	a_rx_trig: assert property (p_rx_trig) else $error("rx ready not low at trigger"); // RL1
	property p_tx_full;
		tx_level == 5'(`FIFO_DEPTH) |=> TX_DMA_READY_N;
	endproperty
	a_tx_full: assert property (p_tx_full) else $error("tx ready low while full"); // RL4
	property p_tx_space;
		tx_level != 5'(`FIFO_DEPTH) && tx_free >= trig_level(st_r.trig[7:4]) |=> !TX_DMA_READY_N;
	endproperty
	a_tx_space: assert property (p_tx_space) else $error("tx ready not low with space"); // RL3
	property p_loop_idle;
		st_r.modem_control_reg[`MCR_LOOP] |=> TX;
	endproperty
	a_loop_idle: assert property (p_loop_idle) else $error("tx pin driven in loopback"); // RL5
	property p_rts;
		st_r.modem_control_reg[`MCR_RTS] |=> !REQUEST_TO_SEND_N;
	endproperty
	a_rts: assert property (p_rts) else $error("rts not low when set"); // RL11
	property p_msr;
		rd_fall && addr == `ADDR_MSR |=> DATA_OUT[`MSR_CTS] == !$past(st_r.s2[`PIN_CTS]);
	endproperty
	a_msr: assert property (p_msr) else $error("msr cts bit wrong"); // RL9
	property p_auto_cts;
		st_r.enhanced_feature_reg[`EFR_AUTO_CTS] && st_r.s2[`PIN_CTS] && !st_r.tx_busy |=> !st_r.tx_busy;
	endproperty
	a_auto_cts: assert property (p_auto_cts) else $error("tx started while cts held off"); // RL10
	property p_deselect;
		st_r.wr_prev && !st_r.s2[`PIN_WR] && st_r.s2[`PIN_CS] |=> $stable(st_r.modem_control_reg) ##0 $stable(st_r.enhanced_feature_reg);
	endproperty
	a_deselect: assert property (p_deselect) else $error("write taken while deselected"); // RL7
	property p_mcr_write;
		wr_fall && addr == `ADDR_MCR |=> st_r.modem_control_reg == $past(st_r.s2[7:0]);
	endproperty
	a_mcr_write: assert property (p_mcr_write) else $error("mcr write not stored"); // RL6
	c_loop_char: cover property (st_r.modem_control_reg[`MCR_LOOP] && rx_push);
	c_timeout: cover property (st_r.to_flag && !RX_DMA_READY_N);
	c_tx_full: cover property (tx_level == 5'(`FIFO_DEPTH));
	c_cts_hold: cover property (tx_out_valid && !st_r.tx_busy && !tx_start);
endmodule
`default_nettype wire

/* pkg/uart_pins_consts.svh */
// constants for the serial channel pin signalling block
`ifndef UART_PINS_CONSTS_SVH
`define UART_PINS_CONSTS_SVH
`define FIFO_DEPTH 16
`define FIFO_CW 5
`define DATA_W 8
`define BIT_CYCLES 8'hd9
`define HALF_BIT_CYCLES 8'h6c
`define LAST_BIT 4'h9
`define PIN_CTS 15
`define PIN_RX 14
`define PIN_WR 13
`define PIN_RD 12
`define PIN_CS 11
`define PIN_ADDR_HI 10
`define PIN_ADDR_LO 8
`define ADDR_DATA 3'h0
`define ADDR_TRIG 3'h1
`define ADDR_EFR 3'h2
`define ADDR_MCR 3'h4
`define ADDR_LSR 3'h5
`define ADDR_MSR 3'h6
`define MCR_RTS 1
`define MCR_LOOP 4
`define EFR_AUTO_CTS 7
`define MSR_CTS 4
`define LSR_RX_AVAIL 0
`define LSR_RX_ERR 3
`define LSR_TX_EMPTY 5
`define ERR_BIT 8
`define TRIG_RST 8'h11
`define REG_RST 8'h00
`define PINS_RST 16'hf800
`endif

/* pkg/uart_pins_pkg.sv */
// types for the serial channel pin signalling block
`default_nettype none
`include "uart_pins_consts.svh"
package uart_pins_pkg;
	typedef struct packed {
		logic [15:0] s1;
		logic [15:0] s2;
		logic wr_prev;
		logic rd_prev;
		logic [7:0] modem_control_reg;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] trig;
		logic tx_busy;
		logic [9:0] tx_sh;
		logic [3:0] tx_bits;
		logic [7:0] tx_cnt;
		logic rx_busy;
		logic [7:0] rx_sh;
		logic [3:0] rx_bits;
		logic [7:0] rx_cnt;
		logic [15:0] to_cnt;
		logic to_flag;
		logic [4:0] err_cnt;
		logic rx_rdy_n;
		logic tx_rdy_n;
		logic tx_pin;
		logic rts_n;
		logic [7:0] rdata;
	} chan_state_type;
endpackage
`default_nettype wire

/* testbench/modem_model.sv */
// modem side model: serial line into the channel, clear-to-send, tx capture
`timescale 1ns/1ps
`default_nettype none
module modem_model #(parameter int BIT = 217) (
	input wire logic clock,
	input wire logic tx,
	output logic rx,
	output logic cts_n
);
	logic [7:0] got;
	int n_got;
	initial begin
		rx = 1'b1;
		cts_n = 1'b1;
		got = 8'h00;
		n_got = 0;
	end
	task automatic set_ready(input logic r);
		cts_n = ~r;
	endtask
	// stop low makes a framing error on purpose
	task automatic send(input logic [7:0] b, input logic stop);
		for (int i = 0; i < 10; i++) begin
			rx = (i == 0) ? 1'b0 : ((i == 9) ? stop : b[i-1]);
			repeat (BIT) @(negedge clock);
		end
		rx = 1'b1;
	endtask
	always begin
		@(negedge tx);
		// sample mid-bit on the falling edge, clear of the edge that launches tx
		repeat (BIT + BIT / 2) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			got[i] = tx;
			repeat (BIT) @(negedge clock);
		end
		n_got++;
	end
endmodule
`default_nettype wire

/* testbench/test_uart_channel.sv */
// self-checking bench for one serial channel
`timescale 1ns/1ps
`default_nettype none
`include "uart_pins_consts.svh"
module test_uart_channel;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cs_n = 1'b1;
	logic [2:0] addr = 3'h0;
	logic wr_n = 1'b1;
	logic rd_n = 1'b1;
	logic [7:0] din = 8'h00;
	logic [7:0] dout;
	logic [7:0] rd;
	logic cts_n, rts_n, rx, tx, rx_rdy_n, tx_rdy_n;
	int n_errors = 0;
	int num_checks = 0;
	always #20 clock = ~clock;
	// long timeout keeps one char below trigger from looking like a timeout
	uart_channel #(.RX_TIMEOUT_CYCLES(16'h1000)) u_dut (.CLOCK(clock), .RST(rst), .CHANNEL_SELECT_N(cs_n),
		.REG_SELECT_BIT0(addr[0]), .REG_SELECT_BIT1(addr[1]), .REG_SELECT_BIT2(addr[2]), .WRITE_STROBE_N(wr_n),
		.READ_STROBE_N(rd_n), .DATA_IN(din), .DATA_OUT(dout), .CLEAR_TO_SEND_N(cts_n),
		.REQUEST_TO_SEND_N(rts_n), .RX(rx), .TX(tx), .RX_DMA_READY_N(rx_rdy_n), .TX_DMA_READY_N(tx_rdy_n));
	modem_model u_modem (.clock(clock), .tx(tx), .rx(rx), .cts_n(cts_n));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (8) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
	endtask
	// strobes and select held well past the three-clock sync window
	task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d, input logic sel_n);
		addr = a;
		din = d;
		cs_n = sel_n;
		repeat (4) @(negedge clock);
		if (wr) wr_n = 1'b0;
		else rd_n = 1'b0;
		repeat (6) @(negedge clock);
		rd = dout;
		wr_n = 1'b1;
		rd_n = 1'b1;
		repeat (5) @(negedge clock);
		cs_n = 1'b1;
		@(negedge clock);
	endtask
	task automatic wait_rdy(input string what, input logic tx_side, input logic lvl, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			if ((tx_side ? tx_rdy_n : rx_rdy_n) === lvl) break;
			@(negedge clock);
		end
		chk(what, {7'h00, lvl}, {7'h00, tx_side ? tx_rdy_n : rx_rdy_n});
	endtask
	task automatic t_reset();
		do_reset();
		chk("rts", 8'h01, {7'h00, rts_n});
		chk("rx ready", 8'h01, {7'h00, rx_rdy_n});
		chk("tx ready", 8'h00, {7'h00, tx_rdy_n});
		chk("tx", 8'h01, {7'h00, tx});
		access(1'b0, 3'h3, 8'h00, 1'b0);
		chk("unmapped", 8'h00, rd);
		$display("test reset done");
	endtask
	task automatic t_rts();
		access(1'b1, `ADDR_MCR, 8'h02, 1'b1);
		chk("rts deselected", 8'h01, {7'h00, rts_n});
		access(1'b1, `ADDR_MCR, 8'h02, 1'b0);
		chk("rts on", 8'h00, {7'h00, rts_n});
		access(1'b0, `ADDR_MCR, 8'h00, 1'b0);
		chk("mcr", 8'h02, rd);
		access(1'b0, 3'h3, 8'h00, 1'b0);
		chk("unmapped after read", 8'h00, rd);
		access(1'b1, `ADDR_MCR, 8'h00, 1'b0);
		chk("rts off", 8'h01, {7'h00, rts_n});
		$display("test rts done");
	endtask
	task automatic t_cts();
		u_modem.set_ready(1'b1);
		access(1'b0, `ADDR_MSR, 8'h00, 1'b0);
		chk("cts on", 8'h01, {7'h00, rd[`MSR_CTS]});
		u_modem.set_ready(1'b0);
		access(1'b0, `ADDR_MSR, 8'h00, 1'b0);
		chk("cts off", 8'h00, {7'h00, rd[`MSR_CTS]});
		$display("test cts done");
	endtask
	task automatic t_rx();
		do_reset();
		access(1'b1, `ADDR_TRIG, 8'h12, 1'b0);
		access(1'b0, `ADDR_TRIG, 8'h00, 1'b0);
		chk("trigger", 8'h12, rd);
		u_modem.send(8'ha5, 1'b1);
		repeat (20) @(negedge clock);
		chk("rx below trigger", 8'h01, {7'h00, rx_rdy_n});
		u_modem.send(8'h5a, 1'b1);
		wait_rdy("rx at trigger", 1'b0, 1'b0, 30);
		access(1'b0, `ADDR_DATA, 8'h00, 1'b0);
		chk("rx byte 1", 8'ha5, rd);
		access(1'b0, `ADDR_DATA, 8'h00, 1'b0);
		chk("rx byte 2", 8'h5a, rd);
		wait_rdy("rx empty", 1'b0, 1'b1, 8);
		u_modem.send(8'h77, 1'b1);
		wait_rdy("rx timeout", 1'b0, 1'b0, 4200);
		access(1'b0, `ADDR_DATA, 8'h00, 1'b0);
		chk("rx byte 3", 8'h77, rd);
		u_modem.send(8'h11, 1'b1);
		u_modem.send(8'h22, 1'b0);
		repeat (30) @(negedge clock);
		chk("rx errored", 8'h01, {7'h00, rx_rdy_n});
		access(1'b0, `ADDR_LSR, 8'h00, 1'b0);
		chk("line status", 8'h29, rd);
		$display("test receive done");
	endtask
	task automatic t_loop();
		int lows;
		do_reset();
		lows = 0;
		access(1'b1, `ADDR_MCR, 8'h10, 1'b0);
		access(1'b1, `ADDR_DATA, 8'hc3, 1'b0);
		for (int i = 0; i < 3000 && rx_rdy_n !== 1'b0; i++) begin
			if (tx !== 1'b1) lows++;
			@(negedge clock);
		end
		chk("tx idle in loop", 8'h00, lows[7:0]);
		access(1'b0, `ADDR_DATA, 8'h00, 1'b0);
		chk("looped byte", 8'hc3, rd);
		$display("test loopback done");
	endtask
	task automatic t_tx_full();
		do_reset();
		u_modem.set_ready(1'b0);
		access(1'b1, `ADDR_EFR, 8'h80, 1'b0);
		access(1'b0, `ADDR_EFR, 8'h00, 1'b0);
		chk("efr", 8'h80, rd);
		for (int i = 0; i < 16; i++) begin
			if (i == 15) chk("tx one free", 8'h00, {7'h00, tx_rdy_n});
			access(1'b1, `ADDR_DATA, 8'h30 + i[7:0], 1'b0);
		end
		chk("tx full", 8'h01, {7'h00, tx_rdy_n});
		chk("tx held", 8'h01, {7'h00, tx});
		u_modem.set_ready(1'b1);
		for (int i = 0; i < 3000 && u_modem.n_got == 0; i++) @(negedge clock);
		chk("first sent", 8'h30, u_modem.got);
		wait_rdy("tx space back", 1'b1, 1'b0, 3000);
		$display("test transmit done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clock);
		n_errors++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial begin
		t_reset();
		t_rts();
		t_cts();
		t_rx();
		t_loop();
		t_tx_full();
		tally_and_finish();
	end
endmodule
`default_nettype wire
